/* rtl/fecl_top.sv */
/*
  Register side of an embedded flash controller: ECC fault window, option
  byte load at reset, reserved test registers, clock divider and the
  command launch handshake toward the flash array.
  Assumes a plain register port driven synchronously to ref_clk, and a
  flash array that answers each request with a one-cycle acknowledge.
*/
// Local design decisions: strobed register access and the placing of the registers.
//
// Contract
// - Captured fault locks until flag cleared.
// - Double-bit fault recorded over single-bit.
// - Index 000 gives parity, address high bits.
// - Index 001 gives low address bits.
// - Parity field, data-flash uses six bits.
// - Program-flash phrase at indices 010-101, raw.
// - Data-flash word at index 010 only.
// - Indices 110 and 111 read zero.
// - Result readable, writes ignored.
// - Option byte loaded at reset sequence.
// - Double fault on load sets all ones.
// - Reserved test registers read zero.
// - Divider write when not busy sets loaded flag.
// - Unloaded divider refuses program/erase, access error.
// - Busy ignores new launch, array writes.
// - Write one launches; flag returns at completion.
// - Indexed array access; valid commands launch.
// - Word 000 holds command and high address.
// - Array indices 110, 111 ignored, read zero.
`timescale 1ns/1ps
`include "fecl_params.svh"
module fecl_top
  import fecl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`FECL_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic ecc_sgl_fault,
  input wire logic ecc_dbl_fault,
  input wire fecl_fault_t ecc_fault,
  output logic nv_rd_req,
  output logic [22:0] nv_rd_addr,
  input wire logic nv_rd_ack,
  input wire logic [7:0] nv_rd_data,
  input wire logic nv_rd_dbl_fault,
  output logic cmd_launch,
  output fecl_words_t cmd_words,
  input wire logic cmd_done,
  input wire logic cmd_prot_viol,
  input wire logic cmd_acc_err,
  input wire fecl_words_t cmd_result,
  output logic flash_time_base_tick
);
  fecl_state_t state_reg;
  logic [6:0] divide_value_reg;
  logic divider_loaded_flag_reg;
  logic [2:0] parameter_index_reg;
  logic [2:0] ecc_result_index_reg;
  logic command_complete_flag_reg;
  logic access_error_flag_reg;
  logic protection_violation_flag_reg;
  logic [7:0] nonvolatile_option_byte_reg;
  logic [6:0] tick_cnt_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic launch_reg;
  logic busy_refuse;

  logic wr_clkdiv;
  logic wr_pidx;
  logic wr_eidx;
  logic wr_stat;
  logic wr_eccstat;
  logic wr_parray;
  logic launch_req;
  logic is_pgm_ers;
  logic launch_ok;
  logic launch_bad;
  logic [1:0] ecc_flags;
  logic [1:0] ecc_clr;
  logic [15:0] ecc_fault_result;
  logic [15:0] param_rd_word;
  logic [7:0] command_code;

  // Register write decode.
  assign wr_clkdiv = reg_wr && reg_addr == `FECL_OFS_CLKDIV;
  assign wr_pidx = reg_wr && reg_addr == `FECL_OFS_PIDX;
  assign wr_eidx = reg_wr && reg_addr == `FECL_OFS_EIDX;
  assign wr_stat = reg_wr && reg_addr == `FECL_OFS_STAT;
  assign wr_eccstat = reg_wr && reg_addr == `FECL_OFS_ECCSTAT;

  assign busy_refuse = !command_complete_flag_reg;
  assign wr_parray = reg_wr && reg_addr == `FECL_OFS_PARRAY && !busy_refuse;

  assign launch_req = wr_stat && reg_wdata[`FECL_BIT_COMMAND_COMPLETE_FLAG] && state_reg == FECL_IDLE
    && command_complete_flag_reg;

  assign command_code = cmd_words[`FECL_IDX_HDR][15:8];

  always_comb begin
    case (command_code)
      `FECL_CMD_PGM_P,
      `FECL_CMD_PGM_ONCE,
      `FECL_CMD_ERS_ALL,
      `FECL_CMD_ERS_BLK,
      `FECL_CMD_ERS_PSEC,
      `FECL_CMD_UNSEC,
      `FECL_CMD_PGM_D,
      `FECL_CMD_ERS_DSEC: is_pgm_ers = 1'b1;
      default: is_pgm_ers = 1'b0;
    endcase
  end

  assign launch_bad = launch_req && ((is_pgm_ers && !divider_loaded_flag_reg)
    || access_error_flag_reg || protection_violation_flag_reg);
  assign launch_ok = launch_req && !launch_bad;

  assign ecc_clr[1] = wr_eccstat && reg_wdata[`FECL_BIT_ECC_DBL];
  assign ecc_clr[0] = wr_eccstat && reg_wdata[`FECL_BIT_ECC_SGL];

  fecl_ecc_capture u_ecc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sgl_fault(ecc_sgl_fault),
    .dbl_fault(ecc_dbl_fault),
    .fault_in(ecc_fault),
    .flag_clr(ecc_clr),
    .ecc_result_index(ecc_result_index_reg),
    .flags(ecc_flags),
    .ecc_fault_result(ecc_fault_result)
  );

  fecl_param_array #(
    .WORDS(6)
  ) u_parray (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_en(wr_parray),
    .parameter_index(parameter_index_reg),
    .wr_data(reg_wdata),
    .res_load(cmd_done && state_reg == FECL_BUSY),
    .res_words(cmd_result),
    .words(cmd_words),
    .rd_word(param_rd_word)
  );

  // Reset sequence, idle and command execution.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FECL_LOAD_REQ;
    end else begin
      case (state_reg)
        FECL_LOAD_REQ: state_reg <= FECL_LOAD_WAIT;
        FECL_LOAD_WAIT: begin
          if (nv_rd_ack) begin
            state_reg <= FECL_IDLE;
          end
        end
        FECL_IDLE: begin
          if (launch_ok) begin
            state_reg <= FECL_BUSY;
          end
        end
        FECL_BUSY: begin
          if (cmd_done) begin
            state_reg <= FECL_IDLE;
          end
        end
        default: state_reg <= FECL_IDLE;
      endcase
    end
  end

  assign nv_rd_req = state_reg == FECL_LOAD_REQ;
  assign nv_rd_addr = `FECL_NV_ADDR;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nonvolatile_option_byte_reg <= `FECL_RST_OPTION;
    end else if (state_reg == FECL_LOAD_WAIT && nv_rd_ack) begin
      nonvolatile_option_byte_reg <= nv_rd_dbl_fault ? `FECL_OPTION_DBL : nv_rd_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      command_complete_flag_reg <= 1'b0;
    end else if (state_reg == FECL_LOAD_WAIT && nv_rd_ack) begin
      command_complete_flag_reg <= 1'b1;
    end else if (launch_ok) begin
      command_complete_flag_reg <= 1'b0;
    end else if (state_reg == FECL_BUSY && cmd_done) begin
      command_complete_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      launch_reg <= 1'b0;
    end else begin
      launch_reg <= launch_ok;
    end
  end

  assign cmd_launch = launch_reg;

  // Error flags: hardware set wins over a software clear.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      access_error_flag_reg <= 1'b0;
    end else begin
      access_error_flag_reg <= (access_error_flag_reg
        & ~(wr_stat && reg_wdata[`FECL_BIT_ACCESS_ERROR_FLAG]))
        | launch_bad | (state_reg == FECL_BUSY && cmd_done && cmd_acc_err);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      protection_violation_flag_reg <= 1'b0;
    end else begin
      protection_violation_flag_reg <= (protection_violation_flag_reg
        & ~(wr_stat && reg_wdata[`FECL_BIT_PVIOL]))
        | (state_reg == FECL_BUSY && cmd_done && cmd_prot_viol);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divide_value_reg <= `FECL_RST_DIV;
      divider_loaded_flag_reg <= 1'b0;
    end else if (wr_clkdiv && !busy_refuse) begin
      divide_value_reg <= reg_wdata[6:0];
      divider_loaded_flag_reg <= 1'b1;
    end
  end

  // Time base enable: one pulse every divide_value+1 cycles once loaded.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= `FECL_RST_DIV;
      flash_time_base_tick <= 1'b0;
    end else if (!divider_loaded_flag_reg || wr_clkdiv) begin
      tick_cnt_reg <= `FECL_RST_DIV;
      flash_time_base_tick <= 1'b0;
    end else if (tick_cnt_reg >= divide_value_reg) begin
      tick_cnt_reg <= `FECL_RST_DIV;
      flash_time_base_tick <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 7'd1;
      flash_time_base_tick <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      parameter_index_reg <= `FECL_RST_IDX;
    end else if (wr_pidx) begin
      parameter_index_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ecc_result_index_reg <= `FECL_RST_IDX;
    end else if (wr_eidx) begin
      ecc_result_index_reg <= reg_wdata[2:0];
    end
  end

  // Read multiplexer; data stand one cycle after the read strobe.
  always_comb begin
    rdata_next = `FECL_ZERO16;
    case (reg_addr)
      `FECL_OFS_CLKDIV: begin
        rdata_next[`FECL_BIT_DIVLD] = divider_loaded_flag_reg;
        rdata_next[6:0] = divide_value_reg;
      end
      `FECL_OFS_PIDX: rdata_next[2:0] = parameter_index_reg;
      `FECL_OFS_EIDX: rdata_next[2:0] = ecc_result_index_reg;
      `FECL_OFS_STAT: begin
        rdata_next[`FECL_BIT_COMMAND_COMPLETE_FLAG] = command_complete_flag_reg;
        rdata_next[`FECL_BIT_ACCESS_ERROR_FLAG] = access_error_flag_reg;
        rdata_next[`FECL_BIT_PVIOL] = protection_violation_flag_reg;
      end
      `FECL_OFS_ECCSTAT: rdata_next[1:0] = ecc_flags;
      `FECL_OFS_PARRAY: rdata_next = param_rd_word;
      `FECL_OFS_ECCRES: rdata_next = ecc_fault_result;
      `FECL_OFS_OPTION: rdata_next[7:0] = nonvolatile_option_byte_reg;
      `FECL_OFS_RSVD_A,
      `FECL_OFS_RSVD_B,
      `FECL_OFS_RSVD_C,
      `FECL_OFS_RSVD_D: rdata_next = `FECL_ZERO16;
      default: rdata_next = `FECL_ZERO16;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= `FECL_ZERO16;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `FECL_ZERO16;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule // fecl_top

/* shared/fecl_params.svh */
/*
  Constants of the flash ECC capture and command launch block: register
  offsets, field positions, reset values and command codes.
  Assumes inclusion by bare name from the design modules and the bench files.
*/
`ifndef FECL_PARAMS_SVH
`define FECL_PARAMS_SVH

`define FECL_ADDR_W 4
`define FECL_OFS_CLKDIV 4'h0
`define FECL_OFS_PIDX 4'h1
`define FECL_OFS_EIDX 4'h2
`define FECL_OFS_STAT 4'h3
`define FECL_OFS_ECCSTAT 4'h4
`define FECL_OFS_PARRAY 4'h5
`define FECL_OFS_ECCRES 4'h6
`define FECL_OFS_OPTION 4'h7
`define FECL_OFS_RSVD_A 4'h8
`define FECL_OFS_RSVD_B 4'h9
`define FECL_OFS_RSVD_C 4'hA
`define FECL_OFS_RSVD_D 4'hB

`define FECL_BIT_DIVLD 7
`define FECL_BIT_COMMAND_COMPLETE_FLAG 7
`define FECL_BIT_ACCESS_ERROR_FLAG 5
`define FECL_BIT_PVIOL 4
`define FECL_BIT_ECC_DBL 1
`define FECL_BIT_ECC_SGL 0

`define FECL_RST_DIV 7'h00
`define FECL_RST_IDX 3'h0
`define FECL_RST_OPTION 8'h00
`define FECL_OPTION_DBL 8'hFF
`define FECL_ZERO16 16'h0000
`define FECL_NV_ADDR 23'h7F_FF0E

`define FECL_IDX_HDR 3'h0
`define FECL_IDX_ALO 3'h1
`define FECL_IDX_D0 3'h2
`define FECL_IDX_D1 3'h3
`define FECL_IDX_D2 3'h4
`define FECL_IDX_D3 3'h5

`define FECL_CMD_PGM_P 8'h06
`define FECL_CMD_PGM_ONCE 8'h07
`define FECL_CMD_ERS_ALL 8'h08
`define FECL_CMD_ERS_BLK 8'h09
`define FECL_CMD_ERS_PSEC 8'h0A
`define FECL_CMD_UNSEC 8'h0B
`define FECL_CMD_PGM_D 8'h11
`define FECL_CMD_ERS_DSEC 8'h12

`endif

/* shared/fecl_pkg.sv */
/*
  Types of the flash ECC capture and command launch block.
  Assumes the constants header sits on the include path.
*/
package fecl_pkg;
  typedef struct packed {
    logic is_pflash;
    logic [22:0] addr;
    logic [63:0] data;
    logic [7:0] parity;
  } fecl_fault_t;

  typedef logic [5:0][15:0] fecl_words_t;

  typedef enum logic [1:0] {
    FECL_LOAD_REQ,
    FECL_LOAD_WAIT,
    FECL_IDLE,
    FECL_BUSY
  } fecl_state_t;
endpackage

/* rtl/fecl_ecc_capture.sv */
/*
  ECC fault capture: sticky fault flags and the locked result window.
  Assumes fault strobes are one-cycle pulses synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "fecl_params.svh"
module fecl_ecc_capture
  import fecl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sgl_fault,
  input wire logic dbl_fault,
  input wire fecl_fault_t fault_in,
  input wire logic [1:0] flag_clr,
  input wire logic [2:0] ecc_result_index,
  output logic [1:0] flags,
  output logic [15:0] ecc_fault_result
);
  logic [1:0] flag_reg;
  fecl_fault_t held_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      held_reg <= '0;
    end else if ((sgl_fault || dbl_fault) && (flag_reg & ~flag_clr) == 2'b00) begin
      held_reg <= fault_in;
    end
  end

  // A fault arriving with a clear keeps its flag set.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= 2'b00;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | {dbl_fault, sgl_fault & ~dbl_fault};
    end
  end

  assign flags = flag_reg;

  always_comb begin
    ecc_fault_result = `FECL_ZERO16;
    case (ecc_result_index)
      `FECL_IDX_HDR: ecc_fault_result = {held_reg.is_pflash ? held_reg.parity
        : {2'b00, held_reg.parity[5:0]}, 1'b0, held_reg.addr[22:16]};
      `FECL_IDX_ALO: ecc_fault_result = held_reg.addr[15:0];
      `FECL_IDX_D0: ecc_fault_result = held_reg.data[15:0];
      `FECL_IDX_D1: ecc_fault_result = held_reg.is_pflash ? held_reg.data[31:16] : `FECL_ZERO16;
      `FECL_IDX_D2: ecc_fault_result = held_reg.is_pflash ? held_reg.data[47:32] : `FECL_ZERO16;
      `FECL_IDX_D3: ecc_fault_result = held_reg.is_pflash ? held_reg.data[63:48] : `FECL_ZERO16;
      default: ecc_fault_result = `FECL_ZERO16;
    endcase
  end
endmodule // fecl_ecc_capture

/* rtl/fecl_param_array.sv */
/*
  Command parameter array: six indexed 16-bit words.
  Assumes the caller gates writes while a command is active.
*/
`timescale 1ns/1ps
`include "fecl_params.svh"
module fecl_param_array
  import fecl_pkg::*;
#(
  parameter int WORDS = 6
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [2:0] parameter_index,
  input wire logic [15:0] wr_data,
  input wire logic res_load,
  input wire fecl_words_t res_words,
  output fecl_words_t words,
  output logic [15:0] rd_word
);
  logic [15:0] mem [WORDS];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= `FECL_ZERO16;
      end
    end else if (res_load) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= res_words[i];
      end
    end else if (wr_en && int'(parameter_index) < WORDS) begin
      mem[parameter_index] <= wr_data;
    end
  end

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      words[i] = mem[i];
    end
    rd_word = (int'(parameter_index) < WORDS) ? mem[parameter_index] : `FECL_ZERO16;
  end
endmodule // fecl_param_array

/* tb/fecl_top_chk.sv */
/*
  Checker of the register port, option load and command launch of fecl_top.
  Assumes it is bound to fecl_top and sees only its ports.
*/
`timescale 1ns/1ps
`include "fecl_params.svh"
module fecl_top_chk
  import fecl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`FECL_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic nv_rd_req,
  input wire logic [22:0] nv_rd_addr,
  input wire logic nv_rd_ack,
  input wire logic nv_rd_dbl_fault,
  input wire logic cmd_launch,
  input wire fecl_words_t cmd_words,
  input wire logic cmd_done,
  input wire logic flash_time_base_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic busy_reg;
  logic divld_reg;
  logic launch_wr;
  assign launch_wr = reg_wr && reg_addr == `FECL_OFS_STAT && reg_wdata[`FECL_BIT_COMMAND_COMPLETE_FLAG];
  // Busy spans from the launch pulse to the completion pulse.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (cmd_launch) begin
      busy_reg <= 1'b1;
    end else if (cmd_done) begin
      busy_reg <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divld_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `FECL_OFS_CLKDIV) begin
      divld_reg <= 1'b1;
    end
  end
  sequence s_opt_dbl_rd;
    nv_rd_ack && nv_rd_dbl_fault ##1 reg_rd && reg_addr == `FECL_OFS_OPTION;
  endsequence
  chk_rsvd_read_zero: assert property (reg_rd && reg_addr >= `FECL_OFS_RSVD_A &&
    reg_addr <= `FECL_OFS_RSVD_D |=> reg_rdata == `FECL_ZERO16)
    else $error("reserved register read nonzero");
  chk_nv_addr_fixed: assert property (nv_rd_addr == `FECL_NV_ADDR)
    else $error("option load address wrong");
  chk_nv_req_pulse: assert property (nv_rd_req |=> !nv_rd_req)
    else $error("option load request longer than one cycle");
  chk_opt_dbl_ones: assert property (s_opt_dbl_rd |=> reg_rdata == 16'h00FF)
    else $error("option byte not all ones after double fault");
  chk_launch_has_cause: assert property (cmd_launch |-> $past(launch_wr))
    else $error("launch without a completion flag write");
  chk_busy_no_launch: assert property (busy_reg |-> !cmd_launch)
    else $error("launch while a command is active");
  chk_busy_words_stable: assert property (busy_reg && !cmd_done |=> $stable(cmd_words))
    else $error("parameter array changed while busy");
  chk_tick_needs_div: assert property (!divld_reg |-> !flash_time_base_tick)
    else $error("time base tick before divider load");
  chk_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == `FECL_ZERO16)
    else $error("read data outside the read answer cycle");
endmodule // fecl_top_chk

bind fecl_top fecl_top_chk i_fecl_top_chk (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr),
  .nv_rd_ack(nv_rd_ack), .nv_rd_dbl_fault(nv_rd_dbl_fault), .cmd_launch(cmd_launch),
  .cmd_words(cmd_words), .cmd_done(cmd_done), .flash_time_base_tick(flash_time_base_tick));

/* tb/fecl_top_tb_top.sv */
/*
  Self-checking bench of fecl_top driven through its register port.
  Assumes the bench alone drives every design input.
*/
`timescale 1ns/1ps
`include "fecl_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module fecl_top_tb_top
  import fecl_pkg::*;
;
  logic ref_clk, rstn, reg_wr, reg_rd, ecc_sgl_fault, ecc_dbl_fault;
  logic nv_rd_req, nv_rd_ack, nv_rd_dbl_fault, cmd_launch, cmd_done;
  logic cmd_prot_viol, cmd_acc_err, flash_time_base_tick;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [22:0] nv_rd_addr;
  logic [7:0] nv_rd_data;
  fecl_fault_t ecc_fault, f1, f2, f3;
  fecl_words_t cmd_words, cmd_result, w_exp;
  int n_fail, checks, n_launch, n_tick;
  fecl_top i_fecl_top (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ecc_sgl_fault(ecc_sgl_fault), .ecc_dbl_fault(ecc_dbl_fault), .ecc_fault(ecc_fault),
    .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr), .nv_rd_ack(nv_rd_ack),
    .nv_rd_data(nv_rd_data), .nv_rd_dbl_fault(nv_rd_dbl_fault), .cmd_launch(cmd_launch),
    .cmd_words(cmd_words), .cmd_done(cmd_done), .cmd_prot_viol(cmd_prot_viol),
    .cmd_acc_err(cmd_acc_err), .cmd_result(cmd_result),
    .flash_time_base_tick(flash_time_base_tick));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cmd_launch === 1'b1) n_launch++;
  end
  task summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task fault(input logic s, input logic d, input fecl_fault_t f);
    @(posedge ref_clk);
    ecc_sgl_fault <= s;
    ecc_dbl_fault <= d;
    ecc_fault <= f;
    @(posedge ref_clk);
    ecc_sgl_fault <= 1'b0;
    ecc_dbl_fault <= 1'b0;
  endtask
  // Resets, answers the option load, then reads the option byte at once.
  task nv_load(input logic [7:0] v, input logic dbl, input logic [15:0] e);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    nv_rd_ack <= 1'b1;
    nv_rd_data <= v;
    nv_rd_dbl_fault <= dbl;
    @(posedge ref_clk);
    nv_rd_ack <= 1'b0;
    nv_rd_dbl_fault <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= `FECL_OFS_OPTION;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  function automatic logic [15:0] ecc_exp(fecl_fault_t f, int i);
    if (i == 0) return {f.is_pflash ? f.parity : {2'b00, f.parity[5:0]}, 1'b0, f.addr[22:16]};
    if (i == 1) return f.addr[15:0];
    if (i < 6 && (f.is_pflash || i == 2)) return f.data[16*(i-2) +: 16];
    return 16'h0000;
  endfunction
  task ecc_all(input fecl_fault_t f);
    for (int i = 0; i < 8; i++) begin
      wr(`FECL_OFS_EIDX, 16'(i));
      rdc(`FECL_OFS_ECCRES, ecc_exp(f, i));
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize;
  end
  initial begin
    {rstn, reg_wr, reg_rd, ecc_sgl_fault, ecc_dbl_fault, nv_rd_ack} = '0;
    {nv_rd_dbl_fault, cmd_done, cmd_prot_viol, cmd_acc_err} = '0;
    {reg_addr, reg_wdata, nv_rd_data, ecc_fault} = '0;
    f1 = '{1'b1, 23'h12_3456, 64'h0123_4567_89AB_CDEF, 8'hA5};
    f2 = '{1'b1, 23'h05_0505, 64'h1111_2222_3333_4444, 8'h3C};
    f3 = '{1'b0, 23'h10_0042, 64'h0000_0000_0000_BEEF, 8'hEA};
    for (int i = 0; i < 6; i++) cmd_result[i] = 16'hA000 + 16'(i);
    for (int i = 0; i < 6; i++) w_exp[i] = 16'h4560 + 16'(i);
    w_exp[0] = 16'h0612;
    nv_load(8'h5A, 1'b0, 16'h005A);
    rdc(`FECL_OFS_STAT, 16'h0080);
    rdc(`FECL_OFS_CLKDIV, 16'h0000);
    wr(`FECL_OFS_OPTION, 16'hFFFF);
    rdc(`FECL_OFS_OPTION, 16'h005A);
    for (int a = 8; a < 16; a++) begin
      wr(4'(a), 16'hFFFF);
      rdc(4'(a), 16'h0000);
    end
    $display("test reset and reserved done");
    wr(`FECL_OFS_PIDX, 16'h0000);
    wr(`FECL_OFS_PARRAY, w_exp[0]);
    wr(`FECL_OFS_STAT, 16'h0080);
    rdc(`FECL_OFS_STAT, 16'h00A0);
    `CHK(n_launch, 0)
    wr(`FECL_OFS_STAT, 16'h0020);
    rdc(`FECL_OFS_STAT, 16'h0080);
    $display("test refused launch done");
    wr(`FECL_OFS_CLKDIV, 16'h0003);
    rdc(`FECL_OFS_CLKDIV, 16'h0083);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (flash_time_base_tick === 1'b1) n_tick++;
    end
    `CHK(n_tick, 10)
    for (int i = 0; i < 8; i++) begin
      wr(`FECL_OFS_PIDX, 16'(i));
      wr(`FECL_OFS_PARRAY, (i < 6) ? w_exp[i] : 16'hBEEF);
      rdc(`FECL_OFS_PARRAY, (i < 6) ? w_exp[i] : 16'h0000);
    end
    `CHK(cmd_words, w_exp)
    wr(`FECL_OFS_PIDX, 16'h0001);
    wr(`FECL_OFS_STAT, 16'h0080);
    rdc(`FECL_OFS_STAT, 16'h0000);
    `CHK(n_launch, 1)
    wr(`FECL_OFS_PARRAY, 16'hDEAD);
    wr(`FECL_OFS_STAT, 16'h0080);
    `CHK(cmd_words, w_exp)
    `CHK(n_launch, 1)
    @(posedge ref_clk);
    cmd_done <= 1'b1;
    @(posedge ref_clk);
    cmd_done <= 1'b0;
    rdc(`FECL_OFS_STAT, 16'h0080);
    `CHK(cmd_words, cmd_result)
    rdc(`FECL_OFS_PARRAY, 16'hA001);
    $display("test command launch done");
    fault(1'b1, 1'b1, f1);
    rdc(`FECL_OFS_ECCSTAT, 16'h0002);
    ecc_all(f1);
    fault(1'b1, 1'b0, f2);
    rdc(`FECL_OFS_ECCSTAT, 16'h0003);
    wr(`FECL_OFS_ECCRES, 16'hFFFF);
    ecc_all(f1);
    wr(`FECL_OFS_ECCSTAT, 16'h0003);
    fault(1'b1, 1'b0, f3);
    rdc(`FECL_OFS_ECCSTAT, 16'h0001);
    ecc_all(f3);
    // A fault in the same cycle as the clear of the held flag is captured.
    fork
      wr(`FECL_OFS_ECCSTAT, 16'h0001);
      fault(1'b1, 1'b0, f1);
    join
    rdc(`FECL_OFS_ECCSTAT, 16'h0001);
    ecc_all(f1);
    $display("test ecc capture done");
    nv_load(8'h12, 1'b1, 16'h00FF);
    rdc(`FECL_OFS_CLKDIV, 16'h0000);
    $display("test second reset done");
    summarize;
  end
endmodule // fecl_top_tb_top
